// *** rtl/asfc_pkg.sv ***
// Functional notes
// - Frame sync fall: hold, drive, convert.
// - Sixteen serial clocks per frame and conversion.
// - Track on fourteenth fall, shadow frame at rise.
// - Float output on sixteenth fall unless weak.
// - Frame carries channel tag then twelve result bits.
// - Tag top bit at sync fall, shift on falls.
// - Twelve-bit control word shifted in MSB first.
// - Only first twelve falls feed control word.
// - Write bit one loads all twelve bits, else keep.
// - Settings apply to the next conversion.
// - Shadow mode captures next frame's sixteen bits.
// - Shadow committed at rise, track first channel.
// - Weak bit: weakly drive next tag top bit.
// - Channel field picks next input, mux at fourteen.
// - Bits five and four choose power mode.
// - Sequence and shadow bits steer sequencer.
// - Range bit selects input span.
// - Coding bit selects result format.
// - Power codes: normal, shutdown, auto-off, standby.
// - Four sequencer modes from sequence and shadow.
// - Shadow bits enable channels, ascending order.
package asfc_pkg;
  localparam int FRAME_BITS = 16;
  localparam int CTRL_BITS = 12;
  localparam int RESULT_BITS = 12;
  localparam int TAG_BITS = 4;
  localparam int SYNC_STAGES = 2;
  localparam int BUF_DEPTH = 2;
  localparam int WRITE_POS = 11;
  localparam int SEQ_POS = 10;
  localparam int CH_HI = 9;
  localparam int CH_LO = 6;
  localparam int PM_HI = 5;
  localparam int PM_LO = 4;
  localparam int SHADOW_POS = 3;
  localparam int WEAK_POS = 2;
  localparam int RANGE_POS = 1;
  localparam int CODING_POS = 0;
  localparam logic [4:0] EDGE_CTRL_DONE = 5'h0c;
  localparam logic [4:0] EDGE_TRACK = 5'h0e;
  localparam logic [4:0] EDGE_LAST = 5'h10;
  localparam logic [11:0] CTRL_RESET = 12'h000;
  localparam logic [15:0] SHADOW_RESET = 16'h0000;
  localparam logic [15:0] EMPTY_WORD = 16'h0000;
  localparam logic [1:0] PM_NORMAL = 2'h3;
  localparam logic [1:0] PM_FULL_DOWN = 2'h2;
  localparam logic [1:0] PM_AUTO_DOWN = 2'h1;
  localparam logic [1:0] PM_AUTO_STANDBY = 2'h0;
  localparam logic [1:0] SQ_NONE = 2'h0;
  localparam logic [1:0] SQ_PROGRAM = 2'h1;
  localparam logic [1:0] SQ_KEEP = 2'h2;
  localparam logic [1:0] SQ_CONSEC = 2'h3;
  typedef enum logic {PH_IDLE, PH_FRAME} asfc_phase_type;
endpackage

// *** rtl/asfc_sync.sv ***
module asfc_sync #(
  parameter int WIDTH = 3
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Levels
  input wire logic [WIDTH-1:0] frame_sync_n_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } asfc_sync_type;

  asfc_sync_type cur_ff;
  asfc_sync_type nxt_ff;

  always_comb
  begin
    nxt_ff.meta = frame_sync_n_in;
    nxt_ff.stable = cur_ff.meta;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      cur_ff <= '0;
    else
      cur_ff <= nxt_ff;
  end

  assign sync_out = cur_ff.stable;
endmodule

// *** rtl/asfc_fifo.sv ***
module asfc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [CW-1:0] count;
    logic in_ready;
    logic out_valid;
  } asfc_fifo_type;

  asfc_fifo_type cur_ff;
  asfc_fifo_type nxt_ff;
  logic push;
  logic pop;

  always_comb
  begin
    nxt_ff = cur_ff;
    push = in_valid && cur_ff.in_ready;
    pop = out_ready && cur_ff.out_valid;
    if (push)
    begin
      nxt_ff.mem[cur_ff.wr_ptr] = in_data;
      nxt_ff.wr_ptr = (cur_ff.wr_ptr == LAST_PTR) ? '0 :
        cur_ff.wr_ptr + PW'(1);
    end
    if (pop)
      nxt_ff.rd_ptr = (cur_ff.rd_ptr == LAST_PTR) ? '0 :
        cur_ff.rd_ptr + PW'(1);
    if (push && !pop)
      nxt_ff.count = cur_ff.count + CW'(1);
    else if (pop && !push)
      nxt_ff.count = cur_ff.count - CW'(1);
    nxt_ff.in_ready = (nxt_ff.count != FULL_CNT);
    nxt_ff.out_valid = (nxt_ff.count != '0);
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cur_ff <= '0;
      cur_ff.in_ready <= 1'b1;
    end
    else
      cur_ff <= nxt_ff;
  end

  assign in_ready = cur_ff.in_ready;
  assign out_valid = cur_ff.out_valid;
  assign out_data = cur_ff.mem[cur_ff.rd_ptr];
endmodule

// *** rtl/asfc_top.sv ***
module asfc_top (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Serial port pins
  input wire logic converter_serial_clock,
  input wire logic frame_sync_n,
  input wire logic converter_serial_in,
  output logic converter_serial_out,
  output logic converter_serial_out_oe,
  output logic converter_serial_out_weak_oe,
  // Analog core control
  output logic track_hold_hold,
  output logic [3:0] mux_channel,
  output logic conv_start,
  output logic conv_range,
  output logic conv_coding,
  output logic [1:0] power_mode,
  output logic core_power_on,
  // Conversion results from the analog core
  input wire logic result_valid,
  input wire logic [11:0] result_data,
  output logic result_ready
);
  typedef struct packed {
    asfc_pkg::asfc_phase_type phase;
    logic [4:0] edge_cnt;
    logic sclk_prev;
    logic sync_prev;
    logic [15:0] tx_shift;
    logic [15:0] rx_shift;
    logic [11:0] ctrl;
    logic wrote;
    logic shadow_armed;
    logic shadow_frame;
    logic [15:0] shadow_word;
    logic seq_active;
    logic [15:0] seq_mask;
    logic [3:0] mux_ch;
    logic [3:0] inflight_ch;
    logic hold;
    logic sdo;
    logic sdo_oe;
    logic sdo_weak;
    logic conv_start;
    logic conv_range;
    logic conv_coding;
    logic core_on;
  } asfc_state_type;

  asfc_state_type cur_ff;
  asfc_state_type nxt_ff;

  logic [2:0] pins_sync;
  logic sclk_s;
  logic sync_n_s;
  logic sdin_s;
  logic sclk_fall;
  logic sync_fall;
  logic sync_rise;
  logic buf_valid;
  logic [15:0] buf_data;
  logic buf_pop;
  logic [15:0] rx_nxt;
  logic [15:0] word;
  logic [1:0] sq_mode;
  logic [1:0] pm;

  // Returns the next enabled channel above cur, wrapping to the lowest.
  function automatic logic [3:0] next_in(input logic [15:0] mask,
                                         input logic [3:0] cur);
    logic [3:0] idx;
    logic found;
    logic [3:0] res;
    found = 1'b0;
    res = cur;
    for (int i = 1; i <= 16; i++)
    begin
      idx = cur + i[3:0];
      if (!found && mask[idx])
      begin
        found = 1'b1;
        res = idx;
      end
    end
    return res;
  endfunction

  // Ones from channel zero up to the final channel.
  function automatic logic [15:0] up_to(input logic [3:0] last);
    logic [15:0] m;
    m = '0;
    for (int i = 0; i < 16; i++)
    begin
      if (i[3:0] <= last)
        m[i] = 1'b1;
    end
    return m;
  endfunction

  // Puts the first received bit at index zero, so bit n enables channel n.
  function automatic logic [15:0] flip(input logic [15:0] bits);
    logic [15:0] r;
    r = '0;
    for (int i = 0; i < 16; i++)
    begin
      r[i] = bits[15 - i];
    end
    return r;
  endfunction

  asfc_sync #(
    .WIDTH(3)
  ) u_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .frame_sync_n_in({converter_serial_clock, frame_sync_n, converter_serial_in}),
    .sync_out(pins_sync)
  );

  assign sclk_s = pins_sync[2];
  assign sync_n_s = pins_sync[1];
  assign sdin_s = pins_sync[0];

  // Results wait here until a frame shifts them out.
  // Tag joins result
  asfc_fifo #(
    .WIDTH(asfc_pkg::FRAME_BITS),
    .DEPTH(asfc_pkg::BUF_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .in_valid(result_valid),
    .in_data({cur_ff.inflight_ch, result_data}),
    .in_ready(result_ready),
    .out_valid(buf_valid),
    .out_data(buf_data),
    .out_ready(buf_pop)
  );

  assign sclk_fall = cur_ff.sclk_prev && !sclk_s;
  assign sync_fall = cur_ff.sync_prev && !sync_n_s;
  assign sync_rise = !cur_ff.sync_prev && sync_n_s;
  assign buf_pop = sync_fall && (cur_ff.phase == asfc_pkg::PH_IDLE);
  assign word = buf_valid ? buf_data : asfc_pkg::EMPTY_WORD;

  always_comb
  begin
    nxt_ff = cur_ff;
    nxt_ff.sclk_prev = sclk_s;
    nxt_ff.sync_prev = sync_n_s;
    nxt_ff.conv_start = 1'b0;
    rx_nxt = {cur_ff.rx_shift[14:0], sdin_s};
    sq_mode = {cur_ff.ctrl[asfc_pkg::SEQ_POS],
               cur_ff.ctrl[asfc_pkg::SHADOW_POS]};
    pm = cur_ff.ctrl[asfc_pkg::PM_HI:asfc_pkg::PM_LO];
    case (cur_ff.phase)
      asfc_pkg::PH_IDLE:
      begin
        if (sync_fall)
        begin
          nxt_ff.phase = asfc_pkg::PH_FRAME;
          nxt_ff.edge_cnt = '0;
          nxt_ff.hold = 1'b1;
          nxt_ff.sdo_oe = 1'b1;
          nxt_ff.sdo_weak = 1'b0;
          nxt_ff.sdo = word[15];
          nxt_ff.tx_shift = {word[14:0], 1'b0};
          nxt_ff.conv_start = 1'b1;
          nxt_ff.inflight_ch = cur_ff.mux_ch;
          nxt_ff.conv_range = cur_ff.ctrl[asfc_pkg::RANGE_POS];
          nxt_ff.conv_coding = cur_ff.ctrl[asfc_pkg::CODING_POS];
          nxt_ff.shadow_frame = cur_ff.shadow_armed;
          nxt_ff.shadow_armed = 1'b0;
          nxt_ff.wrote = 1'b0;
          nxt_ff.core_on = (pm != asfc_pkg::PM_FULL_DOWN);
        end
      end
      asfc_pkg::PH_FRAME:
      begin
        if (sync_rise)
        begin
          nxt_ff.phase = asfc_pkg::PH_IDLE;
          if (cur_ff.edge_cnt != asfc_pkg::EDGE_LAST)
          begin
            nxt_ff.sdo_oe = 1'b0;
            nxt_ff.sdo_weak = 1'b0;
            // A cut frame may end before fall fourteen, so track here.
            // Cut frame tracks
            nxt_ff.hold = 1'b0;
          end
          else if (cur_ff.shadow_frame)
          begin
            nxt_ff.seq_mask = cur_ff.shadow_word;
            nxt_ff.seq_active = 1'b1;
            nxt_ff.mux_ch = next_in(cur_ff.shadow_word, 4'hf);
            nxt_ff.hold = 1'b0;
          end
          nxt_ff.shadow_frame = 1'b0;
        end
        else if (sclk_fall && cur_ff.edge_cnt != asfc_pkg::EDGE_LAST)
        begin
          nxt_ff.edge_cnt = cur_ff.edge_cnt + 5'h01;
          nxt_ff.rx_shift = rx_nxt;
          nxt_ff.sdo = cur_ff.tx_shift[15];
          nxt_ff.tx_shift = {cur_ff.tx_shift[14:0], 1'b0};
          if (nxt_ff.edge_cnt == asfc_pkg::EDGE_CTRL_DONE &&
              !cur_ff.shadow_frame)
          begin
            if (rx_nxt[asfc_pkg::WRITE_POS])
            begin
              nxt_ff.ctrl = rx_nxt[11:0];
              nxt_ff.wrote = 1'b1;
              if ({rx_nxt[asfc_pkg::SEQ_POS],
                   rx_nxt[asfc_pkg::SHADOW_POS]} == asfc_pkg::SQ_PROGRAM)
                nxt_ff.shadow_armed = 1'b1;
            end
          end
          if (nxt_ff.edge_cnt == asfc_pkg::EDGE_TRACK &&
              !cur_ff.shadow_frame)
          begin
            nxt_ff.hold = 1'b0;
            sq_mode = {nxt_ff.ctrl[asfc_pkg::SEQ_POS],
                       nxt_ff.ctrl[asfc_pkg::SHADOW_POS]};
            case (sq_mode)
              asfc_pkg::SQ_PROGRAM:
              begin
                // A fresh write of this mode ends any running sequence.
                // Shadow sequence runs
                if (cur_ff.seq_active && !nxt_ff.wrote)
                  nxt_ff.mux_ch = next_in(cur_ff.seq_mask, cur_ff.mux_ch);
                else
                begin
                  nxt_ff.seq_active = 1'b0;
                  nxt_ff.mux_ch = nxt_ff.ctrl[asfc_pkg::CH_HI:asfc_pkg::CH_LO];
                end
              end
              asfc_pkg::SQ_KEEP:
              begin
                if (cur_ff.seq_active)
                  nxt_ff.mux_ch = next_in(cur_ff.seq_mask, cur_ff.mux_ch);
                else
                  nxt_ff.mux_ch = nxt_ff.ctrl[asfc_pkg::CH_HI:asfc_pkg::CH_LO];
              end
              asfc_pkg::SQ_CONSEC:
              begin
                if (cur_ff.wrote || nxt_ff.wrote || !cur_ff.seq_active)
                begin
                  nxt_ff.seq_mask =
                    up_to(nxt_ff.ctrl[asfc_pkg::CH_HI:asfc_pkg::CH_LO]);
                  nxt_ff.seq_active = 1'b1;
                  nxt_ff.mux_ch = 4'h0;
                end
                else
                  nxt_ff.mux_ch = next_in(cur_ff.seq_mask, cur_ff.mux_ch);
              end
              default:
              begin
                nxt_ff.seq_active = 1'b0;
                nxt_ff.mux_ch = nxt_ff.ctrl[asfc_pkg::CH_HI:asfc_pkg::CH_LO];
              end
            endcase
          end
          if (nxt_ff.edge_cnt == asfc_pkg::EDGE_LAST)
          begin
            if (cur_ff.shadow_frame)
              nxt_ff.shadow_word = flip(rx_nxt);
            nxt_ff.sdo_oe = 1'b0;
            if (nxt_ff.ctrl[asfc_pkg::WEAK_POS])
            begin
              nxt_ff.sdo_weak = 1'b1;
              nxt_ff.sdo = cur_ff.inflight_ch[3];
            end
            case (nxt_ff.ctrl[asfc_pkg::PM_HI:asfc_pkg::PM_LO])
              asfc_pkg::PM_NORMAL:
                nxt_ff.core_on = 1'b1;
              asfc_pkg::PM_FULL_DOWN:
                nxt_ff.core_on = 1'b0;
              asfc_pkg::PM_AUTO_DOWN:
                nxt_ff.core_on = 1'b0;
              asfc_pkg::PM_AUTO_STANDBY:
                nxt_ff.core_on = 1'b0;
              default:
                nxt_ff.core_on = 1'b1;
            endcase
          end
        end
      end
      default:
      begin
        nxt_ff.phase = asfc_pkg::PH_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cur_ff <= '0;
      cur_ff.phase <= asfc_pkg::PH_IDLE;
      cur_ff.sclk_prev <= 1'b1;
      cur_ff.sync_prev <= 1'b1;
      cur_ff.ctrl <= asfc_pkg::CTRL_RESET;
      cur_ff.shadow_word <= asfc_pkg::SHADOW_RESET;
      cur_ff.core_on <= 1'b1;
    end
    else
      cur_ff <= nxt_ff;
  end

  assign converter_serial_out = cur_ff.sdo;
  assign converter_serial_out_oe = cur_ff.sdo_oe;
  assign converter_serial_out_weak_oe = cur_ff.sdo_weak;
  assign track_hold_hold = cur_ff.hold;
  assign mux_channel = cur_ff.mux_ch;
  assign conv_start = cur_ff.conv_start;
  assign conv_range = cur_ff.conv_range;
  assign conv_coding = cur_ff.conv_coding;
  assign power_mode = cur_ff.ctrl[asfc_pkg::PM_HI:asfc_pkg::PM_LO];
  assign core_power_on = cur_ff.core_on;
endmodule

// *** sim/asfc_top_assertions.sv ***
module asfc_top_assertions (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Serial port pins
  input wire logic converter_serial_clock,
  input wire logic frame_sync_n,
  input wire logic converter_serial_out,
  input wire logic converter_serial_out_oe,
  input wire logic converter_serial_out_weak_oe,
  // Analog core control
  input wire logic track_hold_hold,
  input wire logic [3:0] mux_channel,
  input wire logic conv_start
);
  logic sclk_ff;
  logic [4:0] cnt_ff;
  logic [4:0] age_ff;
  logic sf;

  // Pin-level serial clock fall inside an open frame.
  assign sf = sclk_ff & ~converter_serial_clock & ~frame_sync_n;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sclk_ff <= 1'b1;
      cnt_ff <= 5'h00;
      age_ff <= 5'h1f;
    end
    else
    begin
      sclk_ff <= converter_serial_clock;
      age_ff <= sf ? 5'h00 : age_ff + {4'h0, age_ff != 5'h1f};
      if ($fell(frame_sync_n))
        cnt_ff <= 5'h00;
      else if (sf)
        cnt_ff <= cnt_ff + 5'h01;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  hold_on_sync_a: assert property ($fell(frame_sync_n) |->
    ##[1:5] (track_hold_hold && converter_serial_out_oe))
    else $error("no hold or drive after frame start");
  start_on_sync_a: assert property ($fell(frame_sync_n) |->
    ##[1:5] conv_start)
    else $error("no conversion start after frame start");
  single_drive_a: assert property (
    !(converter_serial_out_oe && converter_serial_out_weak_oe))
    else $error("strong and weak drive together");
  hold_to_13_a: assert property ((sf && cnt_ff == 5'h0c) |->
    track_hold_hold [*4])
    else $error("tracking resumed before fall fourteen");
  float_at_16_a: assert property ((sf && cnt_ff == 5'h0f) |->
    ##[1:5] !converter_serial_out_oe)
    else $error("output still driven after fall sixteen");
  drive_mid_a: assert property ((sf && cnt_ff == 5'h08) |->
    converter_serial_out_oe [*4])
    else $error("output released mid frame");
  shift_on_fall_a: assert property ((converter_serial_out_oe &&
    $past(converter_serial_out_oe) && $changed(converter_serial_out))
    |-> age_ff < 5'h06)
    else $error("output bit changed without a clock fall");
  mux_at_14_a: assert property ($changed(mux_channel) |->
    cnt_ff >= 5'h0e)
    else $error("mux switched before fall fourteen");
endmodule

bind asfc_top asfc_top_assertions asfc_top_assertions_i (
  .core_clk, .rst_n, .converter_serial_clock, .frame_sync_n,
  .converter_serial_out, .converter_serial_out_oe,
  .converter_serial_out_weak_oe, .track_hold_hold, .mux_channel,
  .conv_start
);

// *** sim/asfc_host.sv ***
module asfc_host (
  // Clock
  input wire logic core_clk,
  // Serial pins
  output logic sclk,
  output logic sync_n,
  output logic sdin,
  input wire logic sdout,
  input wire logic oe,
  // Observation
  input wire logic hold,
  output logic hold_end
);
  timeunit 1ns;
  timeprecision 1ns;
  logic line;

  // Undriven line floats, so a missing drive shows as high impedance (z).
  assign line = oe ? sdout : 1'bz;

  initial
  begin
    sclk = 1'b1;
    sync_n = 1'b1;
    sdin = 1'b0;
    hold_end = 1'b0;
  end

  task automatic half();
    repeat (4) @(negedge core_clk);
  endtask

  // sixteen clocks, first bit is MSB
  task automatic frame(input logic [15:0] din, output logic [15:0] dout);
    sync_n = 1'b0;
    sdin = din[15];
    half();
    for (int i = 15; i >= 0; i--)
    begin
      dout[i] = line;
      sclk = 1'b0;
      half();
      sclk = 1'b1;
      if (i > 0)
        sdin = din[i-1];
      half();
    end
    hold_end = hold;
    sync_n = 1'b1;
    sdin = ~sdin;
    half();
  endtask
endmodule

// *** sim/asfc_top_tb.sv ***
module asfc_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic rvalid = 1'b0;
  logic [11:0] rdata = 12'h000;
  logic sclk, sync_n, sdin, sout, oe, woe, hold, start, rng, cod, pon;
  logic rready, hold_end;
  logic [3:0] mux;
  logic [1:0] pm;
  logic [15:0] dout;
  int err_total = 0;
  int checked = 0;
  int cyc = 0;

  always #50 core_clk = ~core_clk;

  asfc_top asfc_top_i (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .converter_serial_clock(sclk),
    .frame_sync_n(sync_n),
    .converter_serial_in(sdin),
    .converter_serial_out(sout),
    .converter_serial_out_oe(oe),
    .converter_serial_out_weak_oe(woe),
    .track_hold_hold(hold),
    .mux_channel(mux),
    .conv_start(start),
    .conv_range(rng),
    .conv_coding(cod),
    .power_mode(pm),
    .core_power_on(pon),
    .result_valid(rvalid),
    .result_data(rdata),
    .result_ready(rready)
  );

  asfc_host asfc_host_i (
    .core_clk(core_clk),
    .sclk(sclk),
    .sync_n(sync_n),
    .sdin(sdin),
    .sdout(sout),
    .oe(oe),
    .hold(hold),
    .hold_end(hold_end)
  );

  task automatic check(input string what, input logic [15:0] seen,
    input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic push(input logic [11:0] d);
    int n;
    n = 0;
    @(negedge core_clk);
    rvalid = 1'b1;
    rdata = d;
    while (rready !== 1'b1 && n < 3000)
    begin
      @(negedge core_clk);
      n++;
    end
    if (n == 3000)
      err_total++;
    @(negedge core_clk);
    rvalid = 1'b0;
  endtask

  task automatic t_reset();
    check("enables", {oe, woe}, 16'h0000);
    check("mux", {hold, mux}, 16'h0000);
    check("power", {pm, pon}, 16'h0001);
    $display("reset test done");
  endtask

  task automatic t_ctrl();
    asfc_host_i.frame(16'haf35, dout);
    check("empty word", dout, 16'h0000);
    check("track", {hold_end, hold}, 16'h0000);
    check("mux", mux, 16'h000b);
    check("pm", pm, 16'h0003);
    check("format now", {rng, cod}, 16'h0000);
    $display("control test done");
  endtask

  task automatic t_buf();
    push(12'h5a3);
    push(12'h3c6);
    check("full", rready, 16'h0000);
    fork
      push(12'h9e1);
    join_none
    asfc_host_i.frame(16'h4000, dout);
    check("word one", dout, 16'h05a3);
    check("format", {rng, cod}, 16'h0003);
    check("pm kept", pm, 16'h0003);
    asfc_host_i.frame(16'h0000, dout);
    check("word two", dout, 16'h03c6);
    asfc_host_i.frame(16'h0000, dout);
    check("word three", dout, 16'hb9e1);
    $display("buffer test done");
  endtask

  task automatic t_weak();
    asfc_host_i.frame(16'haf70, dout);
    check("weak", {sout, oe, woe}, 16'h0005);
    asfc_host_i.frame(16'haf30, dout);
    check("float", {oe, woe}, 16'h0000);
    $display("weak test done");
  endtask

  task automatic t_power();
    for (int m = 0; m < 4; m++)
    begin
      asfc_host_i.frame({12'ha83 | 12'(m << 4), 4'h0}, dout);
      check("pm", pm, 16'(m));
      check("power", pon, 16'(m == 3));
    end
    $display("power test done");
  endtask

  task automatic t_seq();
    logic [15:0] din [9] = '{16'h0000, 16'h0000, 16'h0000, 16'hcbb0,
      16'h0000, 16'h0000, 16'h0000, 16'he730, 16'h8f30};
    logic [3:0] exp [9] = '{4'h7, 4'h9, 4'h0, 4'h0, 4'h1, 4'h2, 4'h0,
      4'h1, 4'h3};
    asfc_host_i.frame(16'hafb0, dout);
    asfc_host_i.frame(16'h8140, dout);
    check("shadow hold", hold_end, 16'h0001);
    check("first", {hold, mux}, 16'h0000);
    check("pm kept", pm, 16'h0003);
    for (int i = 0; i < 9; i++)
    begin
      asfc_host_i.frame(din[i], dout);
      check("mux", {12'h000, mux}, {12'h000, exp[i]});
    end
    $display("sequencer test done");
  endtask

  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      results();
    end
  end

  initial
  begin
    repeat (5) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge core_clk);
    t_reset();
    t_ctrl();
    t_buf();
    t_weak();
    t_power();
    t_seq();
    results();
  end
endmodule
